// ==== nvm_program_ctrl.sv ====
// EPROM/EEPROM program control with APB register access and option word decode
`timescale 1ns/1ns
// Contract
// - Latch enable clear: EPROM reads normally and program enable forced to zero.
// - Latch enable set: EPROM reads return data unrelated to contents.
// - Stop mode entry returns EPROM control to read state.
// - Never-programmed EPROM byte reads as zero.
// - Reprogramming a byte only adds one bits; ones stay one.
// - Up to eight bytes per group sharing upper address bits.
// - Latch set, program clear: EPROM writes latch address and up to eight bytes.
// - Stop and resets clear EPROM latch enable.
// - Program enable sets only after latch and a write; software clears it only via latch.
// - EPROM state: 00 read, 10 load, 11 programming.
// - Erase select chooses erase or program; frozen once address latched.
// - EEPROM latch set, pump clear: writes latch; clear restores read.
// - Stop and resets clear EEPROM latch enable.
// - Pump bit starts high voltage; needs latched data; cleared via latch only.
// - EEPROM state: 000 read, 010, 011, 110, 111 as decoded.
// - Reset hold 16 cycles if option bit one, else 4064.
// - Watchdog runs after reset if option set, except bootstrap.
// - Watchdog keeps running in wait if option set.
// - Pull-down per pin only while option set and pin is input.
module nvm_program_ctrl
  import nvm_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  // APB slave
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [31:0]             i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic      [31:0]             o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  // System mode
  input  wire logic                    i_stop_mode,
  input  wire logic                    i_wait_mode,
  input  wire logic                    i_bootstrap,
  input  wire logic [7:0]              i_option_word,
  input  wire logic [7:0]              i_portb_dir,
  input  wire logic [7:0]              i_portc_dir,
  // EPROM array side
  input  wire logic [7:0]              i_eprom_rdata,
  output logic      [EPROM_ADDR_W-1:0] o_eprom_addr,
  output logic      [7:0]              o_eprom_byte_en,
  output logic      [63:0]             o_eprom_wdata,
  output logic                         o_eprom_program,
  // EEPROM array side
  output logic      [7:0]              o_eeprom_addr,
  output logic      [7:0]              o_eeprom_wdata,
  output logic                         o_eeprom_erase,
  output logic                         o_eeprom_pump_on,
  // System outputs
  output logic                         o_ext_clock_out_enable,
  output logic                         o_reset_pin_low,
  output sys_opt_t                     o_sys_opt
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic        wr_en;
  logic        rd_en;
  logic        hit_ctrl;
  logic        hit_opt;
  logic        hit_ep;
  logic        hit_ee;
  logic        hit_stat;
  logic        hit_mode;
  logic        mapped;

  assign wr_en    = i_psel && i_penable && i_pwrite;
  assign rd_en    = i_psel && i_penable && !i_pwrite;
  assign hit_ctrl = (i_paddr == CTRL_ADDR);
  assign hit_opt  = (i_paddr == OPTION_ADDR);
  assign hit_ep   = ((i_paddr & EPROM_WIN_MASK) == EPROM_WIN_ADDR);
  assign hit_ee   = (i_paddr[31:8] == EEPROM_WR_ADDR[31:8]) && (i_paddr[1:0] == 2'b00)
                    && (i_paddr[7:2] != 6'h01) && (i_paddr[7:2] != 6'h02);
  assign hit_stat = (i_paddr == STATUS_ADDR);
  assign hit_mode = (i_paddr == MODE_ADDR);
  assign mapped   = hit_ctrl | hit_opt | hit_ep | hit_ee | hit_stat | hit_mode;

  // Reads take one wait state so the registered data stands when ready is high
  logic        rd_wait_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_wait_reg <= 1'b0;
    end else begin
      rd_wait_reg <= rd_en && !rd_wait_reg;
    end
  end

  assign o_pready  = !rd_en || rd_wait_reg;
  assign o_pslverr = i_psel && i_penable && !mapped;

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  logic       ep_latch_reg;
  logic       ep_pgm_reg;
  logic       ee_erase_reg;
  logic       ee_latch_reg;
  logic       ee_pump_reg;
  logic       ext_clock_out_enable_reg;
  logic [7:0] ep_byte_en_reg;
  logic       ee_loaded_reg;
  logic       stop_q_reg;
  logic       stop_entry;
  logic       ctrl_wr;
  logic [7:0] wd;

  assign ctrl_wr    = wr_en && hit_ctrl;
  assign wd         = i_pwdata[7:0];
  assign stop_entry = i_stop_mode && !stop_q_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stop_q_reg <= 1'b0;
    end else begin
      stop_q_reg <= i_stop_mode;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ep_latch_reg <= CTRL_RESET[EPROM_LATCH_BIT];
    end else if (stop_entry) begin
      ep_latch_reg <= 1'b0;
    end else if (ctrl_wr) begin
      ep_latch_reg <= wd[EPROM_LATCH_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ep_pgm_reg <= CTRL_RESET[EPROM_PGM_BIT];
    end else if (stop_entry || (ctrl_wr && !wd[EPROM_LATCH_BIT]) || !ep_latch_reg) begin
      ep_pgm_reg <= 1'b0;
    end else if (ctrl_wr && wd[EPROM_PGM_BIT] && (ep_byte_en_reg != 8'h00)) begin
      ep_pgm_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_clock_out_enable_reg <= CTRL_RESET[EXT_CLOCK_OUT_ENABLE_BIT];
    end else if (ctrl_wr) begin
      ext_clock_out_enable_reg <= wd[EXT_CLOCK_OUT_ENABLE_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ee_latch_reg <= CTRL_RESET[EE_LATCH_BIT];
    end else if (stop_entry) begin
      ee_latch_reg <= 1'b0;
    end else if (ctrl_wr) begin
      ee_latch_reg <= wd[EE_LATCH_BIT];
    end
  end

  // Erase select may be set with the latch; frozen once the address is latched
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ee_erase_reg <= CTRL_RESET[EE_ERASE_BIT];
    end else if (stop_entry || (ctrl_wr && !wd[EE_LATCH_BIT])) begin
      ee_erase_reg <= 1'b0;
    end else if (ctrl_wr && !ee_loaded_reg) begin
      ee_erase_reg <= wd[EE_ERASE_BIT];
    end else if (!ee_latch_reg) begin
      ee_erase_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ee_pump_reg <= CTRL_RESET[EE_PUMP_BIT];
    end else if (stop_entry || !ee_latch_reg || (ctrl_wr && !wd[EE_LATCH_BIT])) begin
      ee_pump_reg <= 1'b0;
    end else if (ctrl_wr && wd[EE_PUMP_BIT] && ee_loaded_reg) begin
      ee_pump_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // EPROM group latches
  // ----------------------------------------
  logic [EPROM_ADDR_W-4:0] ep_group_reg;
  logic [7:0]              ep_data_reg [GROUP_BYTES];
  logic                    ep_wr;

  assign ep_wr = wr_en && hit_ep && ep_latch_reg && !ep_pgm_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ep_byte_en_reg <= 8'h00;
      ep_group_reg   <= '0;
    end else if (!ep_latch_reg) begin
      ep_byte_en_reg <= 8'h00;
    end else if (ep_wr) begin
      // A new group discards bytes of the old one
      if (ep_byte_en_reg == 8'h00 || i_paddr[EPROM_ADDR_W-1:3] != ep_group_reg) begin
        ep_byte_en_reg <= 8'h01 << i_paddr[2:0];
      end else begin
        ep_byte_en_reg <= ep_byte_en_reg | (8'h01 << i_paddr[2:0]);
      end
      ep_group_reg <= i_paddr[EPROM_ADDR_W-1:3];
    end
  end

  genvar g;
  generate
    for (g = 0; g < GROUP_BYTES; g++) begin : g_ep_byte
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          ep_data_reg[g] <= 8'h00;
        end else if (ep_wr && i_paddr[2:0] == 3'(g)) begin
          ep_data_reg[g] <= i_pwdata[7:0];
        end
      end
      // Array only adds ones: a zero in the data leaves the cell as is
      assign o_eprom_wdata[8*g +: 8] = ep_data_reg[g];
    end
  endgenerate

  assign o_eprom_addr    = {ep_group_reg, 3'b000};
  assign o_eprom_byte_en = ep_byte_en_reg;
  assign o_eprom_program = ep_latch_reg && ep_pgm_reg;

  // ----------------------------------------
  // EEPROM latch
  // ----------------------------------------
  logic [7:0] ee_addr_reg;
  logic [7:0] ee_data_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ee_loaded_reg <= 1'b0;
      ee_addr_reg   <= 8'h00;
      ee_data_reg   <= 8'h00;
    end else if (!ee_latch_reg) begin
      ee_loaded_reg <= 1'b0;
    end else if (wr_en && hit_ee && !ee_pump_reg) begin
      ee_loaded_reg <= 1'b1;
      ee_addr_reg   <= i_paddr[9:2];
      ee_data_reg   <= i_pwdata[7:0];
    end
  end

  assign o_eeprom_addr    = ee_addr_reg;
  assign o_eeprom_wdata   = ee_data_reg;
  assign o_eeprom_erase   = ee_erase_reg;
  assign o_eeprom_pump_on = ee_pump_reg;
  assign o_ext_clock_out_enable = ext_clock_out_enable_reg;

  // ----------------------------------------
  // State decode
  // ----------------------------------------
  eprom_state_t  ep_state;
  eeprom_state_t ee_state;

  always_comb begin
    case ({ep_latch_reg, ep_pgm_reg})
      2'b10:   ep_state = EP_LOAD;
      2'b11:   ep_state = EP_PROGRAM;
      default: ep_state = EP_READ;
    endcase
  end

  always_comb begin
    case ({ee_erase_reg, ee_latch_reg, ee_pump_reg})
      3'b010:  ee_state = EE_LOAD_PGM;
      3'b011:  ee_state = EE_BYTE_PGM;
      3'b110:  ee_state = EE_LOAD_ERASE;
      3'b111:  ee_state = EE_BYTE_ERASE;
      default: ee_state = EE_READ;
    endcase
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] junk_reg;

  // Unrelated data while latched: a free running pattern
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      junk_reg <= 8'h5a;
    end else begin
      junk_reg <= {junk_reg[6:0], junk_reg[7] ^ junk_reg[5] ^ junk_reg[4] ^ junk_reg[3]};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_en && !rd_wait_reg) begin
      if (hit_ctrl) begin
        o_prdata <= {26'h000_0000, ep_latch_reg, ep_pgm_reg, ext_clock_out_enable_reg,
                     ee_erase_reg, ee_latch_reg, ee_pump_reg};
      end else if (hit_opt) begin
        o_prdata <= {24'h00_0000, 3'b000, i_option_word[4:0]};
      end else if (hit_ep) begin
        // Erased cells come back as zero from the array itself
        o_prdata <= {24'h00_0000, ep_latch_reg ? junk_reg : i_eprom_rdata};
      end else if (hit_stat) begin
        o_prdata <= {24'h00_0000, 3'b000, ee_state, ep_state};
      end else if (hit_mode) begin
        o_prdata <= {24'h00_0000, ep_byte_en_reg};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Power-on reset hold
  // ----------------------------------------
  logic [11:0] por_cnt_reg;
  logic        por_run_reg;
  logic [11:0] por_len;

  assign por_len = i_option_word[RESET_TIME_BIT] ? POR_SHORT_CYCLES : POR_LONG_CYCLES;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      por_cnt_reg <= 12'h000;
      por_run_reg <= 1'b1;
    end else if (por_run_reg) begin
      if (por_cnt_reg >= por_len - 12'd1) begin
        por_run_reg <= 1'b0;
      end else begin
        por_cnt_reg <= por_cnt_reg + 12'd1;
      end
    end
  end

  assign o_reset_pin_low = por_run_reg;

  // ----------------------------------------
  // Watchdog and pull-downs
  // ----------------------------------------
  logic wd_armed_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wd_armed_reg <= 1'b0;
    end else if (por_run_reg) begin
      wd_armed_reg <= i_option_word[WDOG_RESET_BIT] && !i_bootstrap;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sys_opt <= '0;
    end else begin
      o_sys_opt.wdog_run <= wd_armed_reg
                            && (!i_wait_mode || i_option_word[WDOG_WAIT_BIT]);
      o_sys_opt.portb_pd <= {8{i_option_word[PORTB_PD_BIT]}} & ~i_portb_dir;
      o_sys_opt.portc_pd <= {8{i_option_word[PORTC_PD_BIT]}} & ~i_portc_dir;
    end
  end

endmodule : nvm_program_ctrl

// ==== nvm_ctrl_pkg.sv ====
// Package: register map, field positions and timing for the NVM program control block
package nvm_ctrl_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  // Printed offsets are not all multiples of four: kept as indices
  localparam logic [15:0] CTRL_INDEX    = 16'h0007;
  localparam logic [15:0] OPTION_INDEX  = 16'h3dfe;
  localparam logic [31:0] CTRL_ADDR     = {14'h0000, CTRL_INDEX, 2'b00};
  localparam logic [31:0] OPTION_ADDR   = {14'h0000, OPTION_INDEX, 2'b00};
  // Own choices: window for EPROM latches, EEPROM latch, mode status
  localparam logic [31:0] EPROM_WIN_ADDR  = 32'h0001_0000;
  localparam logic [31:0] EPROM_WIN_MASK  = 32'hffff_0000;
  localparam logic [31:0] EEPROM_WR_ADDR  = 32'h0002_0000;
  localparam logic [31:0] STATUS_ADDR     = 32'h0002_0004;
  localparam logic [31:0] MODE_ADDR       = 32'h0002_0008;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int EPROM_LATCH_BIT  = 5;
  localparam int EPROM_PGM_BIT    = 4;
  localparam int EXT_CLOCK_OUT_ENABLE_BIT         = 3;
  localparam int EE_ERASE_BIT     = 2;
  localparam int EE_LATCH_BIT     = 1;
  localparam int EE_PUMP_BIT      = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------
  // Option word fields
  // ----------------------------------------
  localparam int RESET_TIME_BIT   = 4;
  localparam int WDOG_RESET_BIT   = 3;
  localparam int WDOG_WAIT_BIT    = 2;
  localparam int PORTB_PD_BIT     = 1;
  localparam int PORTC_PD_BIT     = 0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [11:0] POR_SHORT_CYCLES = 12'd16;
  localparam logic [11:0] POR_LONG_CYCLES  = 12'd4064;

  localparam int EPROM_ADDR_W = 14;
  localparam int GROUP_BYTES  = 8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    EP_READ    = 2'b00,
    EP_LOAD    = 2'b10,
    EP_PROGRAM = 2'b11
  } eprom_state_t;

  typedef enum logic [2:0] {
    EE_READ       = 3'b000,
    EE_LOAD_PGM   = 3'b010,
    EE_BYTE_PGM   = 3'b011,
    EE_LOAD_ERASE = 3'b110,
    EE_BYTE_ERASE = 3'b111
  } eeprom_state_t;

  typedef struct packed {
    logic       wdog_run;
    logic [7:0] portb_pd;
    logic [7:0] portc_pd;
  } sys_opt_t;

endpackage : nvm_ctrl_pkg

// ==== nvm_ctrl_chk_properties.sv ====
// Checker: port-level properties of the NVM program control block
`timescale 1ns/1ns
module nvm_ctrl_chk
  import nvm_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // Bus and mode inputs
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        i_stop_mode,
  input wire logic        i_wait_mode,
  input wire logic        i_bootstrap,
  input wire logic [7:0]  i_option_word,
  input wire logic [7:0]  i_portb_dir,
  input wire logic [7:0]  i_portc_dir,
  // Watched outputs
  input wire logic        o_eprom_program,
  input wire logic        o_eeprom_erase,
  input wire logic        o_eeprom_pump_on,
  input wire logic        o_reset_pin_low,
  input wire sys_opt_t    o_sys_opt
);
  // ----
  // Helpers
  // ----
  logic [12:0] cyc_reg;
  logic        boot_reg;
  wire logic        ctrl_wr  = i_psel && i_penable && i_pwrite && (i_paddr == CTRL_ADDR);
  wire logic        pgm_wr   = ctrl_wr && i_pwdata[EPROM_LATCH_BIT] && i_pwdata[EPROM_PGM_BIT];
  wire logic        ep_clr   = ctrl_wr && !i_pwdata[EPROM_LATCH_BIT];
  wire logic        pump_wr  = ctrl_wr && i_pwdata[EE_LATCH_BIT] && i_pwdata[EE_PUMP_BIT];
  wire logic        ee_clr   = ctrl_wr && !i_pwdata[EE_LATCH_BIT];
  wire logic        wait_off = i_wait_mode && !i_option_word[WDOG_WAIT_BIT];
  wire logic [15:0] pd_exp   = {(i_option_word[PORTB_PD_BIT] ? ~i_portb_dir : 8'h00),
                                (i_option_word[PORTC_PD_BIT] ? ~i_portc_dir : 8'h00)};
  // Saturates so long runs never wrap into the hold window
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_reg <= 13'h0000;
    end else if (cyc_reg != 13'h1fff) begin
      cyc_reg <= cyc_reg + 13'h0001;
    end
  end
  // Strap held since reset; watchdog arm is sampled within that span
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_reg <= 1'b1;
    end else if (!i_bootstrap) begin
      boot_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----
  // Properties
  // ----
  property p_pgm_set; $rose(o_eprom_program) |-> $past(pgm_wr); endproperty
  a_pgm_set: assert property (p_pgm_set)
    else $error("program enable rose without a latch write");
  property p_pgm_hold; o_eprom_program && !i_stop_mode && !ep_clr |=> o_eprom_program; endproperty
  a_pgm_hold: assert property (p_pgm_hold)
    else $error("program enable dropped without latch clear");
  property p_stop_clr;
    $rose(i_stop_mode) |-> ##[1:2] (!o_eprom_program && !o_eeprom_pump_on && !o_eeprom_erase);
  endproperty
  a_stop_clr: assert property (p_stop_clr)
    else $error("stop entry left programming active");
  property p_pump_set; $rose(o_eeprom_pump_on) |-> $past(pump_wr); endproperty
  a_pump_set: assert property (p_pump_set)
    else $error("pump rose without a pump write");
  property p_pump_hold; o_eeprom_pump_on && !i_stop_mode && !ee_clr |=> o_eeprom_pump_on; endproperty
  a_pump_hold: assert property (p_pump_hold)
    else $error("pump dropped without latch clear");
  property p_erase_src; $rose(o_eeprom_erase) |-> $past(ctrl_wr); endproperty
  a_erase_src: assert property (p_erase_src)
    else $error("erase rose without a control write");
  property p_hold_time;
    $fell(o_reset_pin_low) |->
      (cyc_reg inside {[13'h000f:13'h0012], [13'h0fdf:13'h0fe2]});
  endproperty
  a_hold_time: assert property (p_hold_time)
    else $error("reset hold length wrong");
  property p_pulldown;
    cyc_reg > 13'h0002 |-> {o_sys_opt.portb_pd, o_sys_opt.portc_pd} == $past(pd_exp);
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("pull-down enables wrong");
  property p_wdog_wait; cyc_reg > 13'h0002 && $past(wait_off) |-> !o_sys_opt.wdog_run; endproperty
  a_wdog_wait: assert property (p_wdog_wait)
    else $error("watchdog running in wait");
  property p_wdog_boot; cyc_reg > 13'h0002 && boot_reg |-> !o_sys_opt.wdog_run; endproperty
  a_wdog_boot: assert property (p_wdog_boot)
    else $error("watchdog running in bootstrap");
endmodule : nvm_ctrl_chk

bind nvm_program_ctrl nvm_ctrl_chk nvm_ctrl_chk_i (
  .i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .i_stop_mode, .i_wait_mode, .i_bootstrap, .i_option_word, .i_portb_dir,
  .i_portc_dir, .o_eprom_program, .o_eeprom_erase, .o_eeprom_pump_on,
  .o_reset_pin_low, .o_sys_opt
);

// ==== tb_top.sv ====
// Testbench: APB-driven scenarios for the NVM program control block
`timescale 1ns/1ns
module tb_top
  import nvm_ctrl_pkg::*;
;
  // ----
  // Signals
  // ----
  logic                    i_clk, i_rst_n, i_psel, i_penable, i_pwrite;
  logic [31:0]             i_paddr, i_pwdata, o_prdata, rdv;
  logic                    o_pready, o_pslverr, serr, i_stop_mode, i_wait_mode, i_bootstrap;
  logic [7:0]              i_option_word, i_portb_dir, i_portc_dir, i_eprom_rdata;
  logic [EPROM_ADDR_W-1:0] o_eprom_addr;
  logic [7:0]              o_eprom_byte_en, o_eeprom_addr, o_eeprom_wdata;
  logic [63:0]             o_eprom_wdata;
  logic                    o_eprom_program, o_eeprom_erase, o_eeprom_pump_on;
  logic                    o_ext_clock_out_enable, o_reset_pin_low;
  sys_opt_t                o_sys_opt;
  int                      errors, checked;

  nvm_program_ctrl nvm_program_ctrl_i (
    .i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_stop_mode, .i_wait_mode, .i_bootstrap,
    .i_option_word, .i_portb_dir, .i_portc_dir, .i_eprom_rdata, .o_eprom_addr,
    .o_eprom_byte_en, .o_eprom_wdata, .o_eprom_program, .o_eeprom_addr,
    .o_eeprom_wdata, .o_eeprom_erase, .o_eeprom_pump_on, .o_ext_clock_out_enable,
    .o_reset_pin_low, .o_sys_opt
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk(32'(got), 32'(exp));
  endtask : chkb
  task automatic finish_test();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  // Ready is awaited, never assumed; data and response are taken at the ready edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 40);
    if (o_pready !== 1'b1) begin
      errors++;
      finish_test();
    end
    serr = o_pslverr;
    rdv = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    // One idle edge lets registered outputs settle before they are compared
    @(posedge i_clk);
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [31:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic rst(input logic [7:0] opt, input logic boot, input int hold);
    int n;
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    i_option_word <= opt;
    i_bootstrap <= boot;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    n = 0;
    while (o_reset_pin_low === 1'b1 && n < 5000) begin
      @(posedge i_clk);
      n++;
    end
    chkb(n >= hold - 1 && n <= hold + 2, 1'b1);
    if (o_reset_pin_low !== 1'b0) begin
      finish_test();
    end
    $display("reset done");
  endtask : rst

  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    rd(CTRL_ADDR);
    chk(rdv, 32'h0000_0000);
    wr(CTRL_ADDR, 32'h0000_0008);
    chkb(o_ext_clock_out_enable, 1'b1);
    rd(CTRL_ADDR);
    chk(rdv, 32'h0000_0008);
    rd(OPTION_ADDR);
    chk(32'(rdv[4:0]), 32'h0000_001B);
    rd(32'h0000_0100);
    chkb(serr, 1'b1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_eprom();
    i_eprom_rdata <= 8'h00;
    rd(EPROM_WIN_ADDR + 32'h0000_0040);
    chk(32'(rdv[7:0]), 32'h0000_0000);
    i_eprom_rdata <= 8'h5A;
    rd(EPROM_WIN_ADDR + 32'h0000_0040);
    chk(32'(rdv[7:0]), 32'h0000_005A);
    wr(CTRL_ADDR, 32'h0000_0030);
    rd(CTRL_ADDR);
    chk(rdv, 32'h0000_0020);
    rd(STATUS_ADDR);
    chk(32'(rdv[1:0]), 32'h0000_0002);
    wr(EPROM_WIN_ADDR + 32'h0000_0200, 32'h0000_0011);
    chk(32'(o_eprom_byte_en), 32'h0000_0001);
    wr(EPROM_WIN_ADDR + 32'h0000_0123, 32'h0000_00A5);
    wr(EPROM_WIN_ADDR + 32'h0000_0125, 32'h0000_003C);
    chk(32'(o_eprom_byte_en), 32'h0000_0028);
    chk(32'(o_eprom_addr), 32'h0000_0120);
    chk(32'({o_eprom_wdata[47:40], o_eprom_wdata[31:24]}), 32'h0000_3CA5);
    wr(CTRL_ADDR, 32'h0000_0030);
    chkb(o_eprom_program, 1'b1);
    rd(STATUS_ADDR);
    chk(32'(rdv[1:0]), 32'h0000_0003);
    wr(EPROM_WIN_ADDR + 32'h0000_0126, 32'h0000_0077);
    chk(32'(o_eprom_byte_en), 32'h0000_0028);
    wr(CTRL_ADDR, 32'h0000_0020);
    chkb(o_eprom_program, 1'b1);
    wr(CTRL_ADDR, 32'h0000_0000);
    chkb(o_eprom_program, 1'b0);
    rd(STATUS_ADDR);
    chk(32'(rdv[1:0]), 32'h0000_0000);
    $display("t_eprom done");
  endtask : t_eprom
  task automatic t_eeprom();
    logic [31:0] c;
    for (int e = 0; e < 2; e++) begin
      c = {29'h0000_0000, e[0], 2'b10};
      wr(CTRL_ADDR, c);
      rd(STATUS_ADDR);
      chk(32'(rdv[4:2]), 32'({e[0], 2'b10}));
      wr(CTRL_ADDR, c | 32'h0000_0001);
      chkb(o_eeprom_pump_on, 1'b0);
      wr(EEPROM_WR_ADDR + 32'h0000_0048, 32'h0000_005A);
      chk(32'({o_eeprom_addr, o_eeprom_wdata}), 32'h0000_125A);
      wr(CTRL_ADDR, c ^ 32'h0000_0004);
      rd(CTRL_ADDR);
      chk(rdv, c);
      wr(CTRL_ADDR, c | 32'h0000_0001);
      chkb(o_eeprom_pump_on, 1'b1);
      chkb(o_eeprom_erase, e[0]);
      rd(STATUS_ADDR);
      chk(32'(rdv[4:2]), 32'({e[0], 2'b11}));
      wr(CTRL_ADDR, c);
      chkb(o_eeprom_pump_on, 1'b1);
      wr(CTRL_ADDR, 32'h0000_0000);
      rd(CTRL_ADDR);
      chk(rdv, 32'h0000_0000);
      chkb(o_eeprom_erase, 1'b0);
    end
    $display("t_eeprom done");
  endtask : t_eeprom
  task automatic t_stop();
    wr(CTRL_ADDR, 32'h0000_0022);
    wr(EPROM_WIN_ADDR + 32'h0000_0001, 32'h0000_0001);
    wr(EEPROM_WR_ADDR + 32'h0000_0010, 32'h0000_0001);
    wr(CTRL_ADDR, 32'h0000_0033);
    rd(CTRL_ADDR);
    chk(rdv, 32'h0000_0033);
    i_stop_mode <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_stop_mode <= 1'b0;
    rd(CTRL_ADDR);
    chk(rdv, 32'h0000_0000);
    chkb(o_eeprom_pump_on, 1'b0);
    $display("t_stop done");
  endtask : t_stop
  task automatic t_opt(input logic wd, input logic wdw, input logic [7:0] pb, input logic [7:0] pc);
    repeat (3) @(posedge i_clk);
    chkb(o_sys_opt.wdog_run, wd);
    chk(32'({o_sys_opt.portb_pd, o_sys_opt.portc_pd}), 32'({pb, pc}));
    i_wait_mode <= 1'b1;
    repeat (3) @(posedge i_clk);
    chkb(o_sys_opt.wdog_run, wdw);
    i_wait_mode <= 1'b0;
    $display("t_opt done");
  endtask : t_opt

  initial begin
    i_rst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 32'h0000_0000;
    i_pwdata = 32'h0000_0000;
    i_stop_mode = 1'b0;
    i_wait_mode = 1'b0;
    i_bootstrap = 1'b0;
    i_option_word = 8'h1B;
    i_portb_dir = 8'h0F;
    i_portc_dir = 8'h3C;
    i_eprom_rdata = 8'h00;
    errors = 0;
    checked = 0;
    rst(8'h1B, 1'b0, 16);
    t_regs();
    t_eprom();
    t_eeprom();
    t_stop();
    t_opt(1'b1, 1'b0, 8'hF0, 8'hC3);
    rst(8'h0C, 1'b0, 4064);
    t_opt(1'b1, 1'b1, 8'h00, 8'h00);
    rst(8'h17, 1'b0, 16);
    t_opt(1'b0, 1'b0, 8'hF0, 8'hC3);
    rst(8'h1B, 1'b1, 16);
    t_opt(1'b0, 1'b0, 8'hF0, 8'hC3);
    finish_test();
  end
endmodule : tb_top
